// ### hw/wdt_cfg.svh
// Purpose: constants for the windowed watchdog timer
// Assumes: 50 MHz system clock
// Notes:   timeout table for the non-default selections is parametric
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// service byte values
`define WDT_SVC_FIRST      8'h55
`define WDT_SVC_SECOND     8'hAA

// system_options_one field: watchdog_timeout_select
`define WDT_TSEL_LSB       6
`define WDT_TSEL_MSB       7
`define WDT_TSEL_RST       2'h3

// system_options_two fields
`define WDT_CLKS_BIT       0
`define WDT_WIN_BIT        1
`define WDT_CLKS_RST       1'h1
`define WDT_WIN_RST        1'h0

// timing
`define WDT_CLK_HZ         50000000
`define WDT_SLOW_HZ        1000
`define WDT_SLOW_DIV       (`WDT_CLK_HZ / `WDT_SLOW_HZ)
`define WDT_LONG_LOG2      10

`endif

// ### hw/wdt_pkg.sv
// Purpose: types for the windowed watchdog timer
// Assumes: nothing
// Notes:   timer state encodings
package wdt_pkg;

    typedef enum logic [2:0] {
        WDT_OFF   = 3'b001,
        WDT_RUN   = 3'b010,
        WDT_HOLD  = 3'b100
    } wdt_state_type;

    typedef logic [1:0] wdt_tsel_type;

endpackage : wdt_pkg

// ### hw/wdt_svc_seq.sv
// Purpose: service sequence decoder for the watchdog
// Assumes: one write strobe per byte
// Notes:   pulses are registered, one cycle after the write
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_svc_seq (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // write port
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    // results
    output logic            first_seen,
    output logic            done,
    output logic            bad_value
);

    logic armed_ff;
    logic nxt_armed;
    logic done_ff;
    logic nxt_done;
    logic bad_ff;
    logic nxt_bad;
    logic first_ff;
    logic nxt_first;

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_armed = armed_ff;
        nxt_done  = 1'b0;
        nxt_bad   = 1'b0;
        nxt_first = 1'b0;
        if (wr_en)
        begin
            if (wr_data == `WDT_SVC_FIRST)
            begin
                nxt_armed = 1'b1;
                nxt_first = 1'b1;
            end
            else if (wr_data == `WDT_SVC_SECOND)
            begin
                nxt_done  = armed_ff;
                nxt_armed = 1'b0;
            end
            else
            begin
                nxt_bad   = 1'b1;
                nxt_armed = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            armed_ff <= 1'b0;
            done_ff  <= 1'b0;
            bad_ff   <= 1'b0;
            first_ff <= 1'b0;
        end
        else
        begin
            armed_ff <= nxt_armed;
            done_ff  <= nxt_done;
            bad_ff   <= nxt_bad;
            first_ff <= nxt_first;
        end
    end

    assign done       = done_ff;
    assign bad_value  = bad_ff;
    assign first_seen = first_ff;

endmodule : wdt_svc_seq

// ### hw/wdt_tick_gen.sv
// Purpose: slow tick generator for the watchdog counter
// Assumes: clk_sys at 50 MHz
// Notes:   clear restarts the divider phase
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_tick_gen #(
    parameter int DIV = `WDT_SLOW_DIV
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // control
    input  wire logic clear,
    // output
    output logic      tick
);

    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          tick_ff;
    logic          nxt_tick;

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_tick = 1'b0;
        nxt_cnt  = cnt_ff + 1'b1;
        if (clear)
        begin
            nxt_cnt = '0;
        end
        else if (cnt_ff == CW'(DIV - 1))
        begin
            nxt_cnt  = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule : wdt_tick_gen

// ### hw/wdt_top.sv
// Purpose: windowed watchdog timer with write-once option registers
// Assumes: byte writes arrive as single-cycle strobes on clk_sys
// Notes:   cause bit clears on block reset; system keeps its own copy
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_top #(
    parameter int BUS_LOG2_1  = 13,
    parameter int BUS_LOG2_2  = 16,
    parameter int BUS_LOG2_3  = 18,
    parameter int SLOW_LOG2_1 = 5,
    parameter int SLOW_LOG2_2 = 8,
    parameter int SLOW_DIV    = `WDT_SLOW_DIV
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // reset cause from the system reset logic
    input  wire logic                  por_cause,
    // register writes
    input  wire logic                  status_wr,
    input  wire logic [7:0]            status_wdata,
    input  wire logic                  opt_one_wr,
    input  wire logic [7:0]            opt_one_wdata,
    input  wire logic                  opt_two_wr,
    input  wire logic [7:0]            opt_two_wdata,
    // low power and debug
    input  wire logic                  stop_mode,
    input  wire logic                  debug_mode,
    // outputs
    output logic                       system_reset_req,
    output logic                       cause_watchdog,
    output wdt_pkg::wdt_tsel_type      timeout_select,
    output logic                       clock_select,
    output logic                       window_enable,
    output logic                       watchdog_running
);

    import wdt_pkg::*;

    localparam int CW = 19;

    ////////////////////////////////////////////////////////////////////
    // option registers
    // first write to each locks it
    wdt_tsel_type  tsel_ff;
    wdt_tsel_type  nxt_tsel;
    logic          clks_ff;
    logic          nxt_clks;
    logic          win_ff;
    logic          nxt_win;
    logic          lock_one_ff;
    logic          nxt_lock_one;
    logic          lock_two_ff;
    logic          nxt_lock_two;
    logic          opt_init;

    always_comb
    begin
        nxt_tsel     = tsel_ff;
        nxt_clks     = clks_ff;
        nxt_win      = win_ff;
        nxt_lock_one = lock_one_ff;
        nxt_lock_two = lock_two_ff;
        opt_init     = 1'b0;
        if (opt_one_wr && !lock_one_ff)
        begin
            nxt_tsel     = opt_one_wdata[`WDT_TSEL_MSB:`WDT_TSEL_LSB];
            nxt_lock_one = 1'b1;
            opt_init     = 1'b1;
        end
        if (opt_two_wr && !lock_two_ff)
        begin
            nxt_clks     = opt_two_wdata[`WDT_CLKS_BIT];
            nxt_win      = opt_two_wdata[`WDT_WIN_BIT];
            nxt_lock_two = 1'b1;
            opt_init     = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            tsel_ff     <= `WDT_TSEL_RST;
            clks_ff     <= `WDT_CLKS_RST;
            win_ff      <= `WDT_WIN_RST;
            lock_one_ff <= 1'b0;
            lock_two_ff <= 1'b0;
        end
        else
        begin
            tsel_ff     <= nxt_tsel;
            clks_ff     <= nxt_clks;
            win_ff      <= nxt_win;
            lock_one_ff <= nxt_lock_one;
            lock_two_ff <= nxt_lock_two;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // service decode and slow tick
    logic svc_done;
    logic svc_bad;
    logic slow_tick;
    logic lowpwr;
    logic tick_clear;

    assign lowpwr = stop_mode | debug_mode;

    wdt_svc_seq u_svc (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .wr_en      (status_wr),
        .wr_data    (status_wdata),
        .first_seen (),
        .done       (svc_done),
        .bad_value  (svc_bad)
    );

    wdt_tick_gen #(
        .DIV (SLOW_DIV)
    ) u_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .clear   (tick_clear),
        .tick    (slow_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // timeout selection
    logic [4:0] limit_log2;

    always_comb
    begin
        limit_log2 = 5'(`WDT_LONG_LOG2);
        unique case ({clks_ff, tsel_ff})
            // bus clock selections
            3'b001:  limit_log2 = 5'(BUS_LOG2_1);
            3'b010:  limit_log2 = 5'(BUS_LOG2_2);
            3'b011:  limit_log2 = 5'(BUS_LOG2_3);
            // 1 kHz source selections
            3'b101:  limit_log2 = 5'(SLOW_LOG2_1);
            3'b110:  limit_log2 = 5'(SLOW_LOG2_2);
            3'b111:  limit_log2 = 5'(`WDT_LONG_LOG2);
            default: limit_log2 = 5'(`WDT_LONG_LOG2);
        endcase
    end

    logic [CW-1:0] limit;
    logic [CW-1:0] win_start;

    assign limit     = CW'(1) << limit_log2;
    assign win_start = limit - (limit >> 2);

    ////////////////////////////////////////////////////////////////////
    // counter state machine
    // run, hold in low power, off when disabled
    wdt_state_type state_ff;
    wdt_state_type nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          rst_req_ff;
    logic          nxt_rst_req;
    logic          cause_ff;
    logic          nxt_cause;
    logic          enabled;
    logic          step;
    logic          windowed;
    logic          early;

    assign enabled    = (tsel_ff != 2'h0);
    assign windowed   = win_ff && !clks_ff;
    assign early      = windowed && (cnt_ff < win_start);
    assign step       = clks_ff ? slow_tick : 1'b1;
    assign tick_clear = opt_init || svc_done || lowpwr;

    // immediate reset requests
    logic bad_req;
    logic early_req;

    assign bad_req   = svc_bad;
    assign early_req = svc_done && early && enabled;

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_rst_req = 1'b0;
        nxt_cause   = cause_ff;
        if (por_cause)
        begin
            nxt_cause = 1'b0;
        end
        unique case (state_ff)
            WDT_OFF:
            begin
                nxt_cnt = '0;
                if (enabled)
                begin
                    nxt_state = WDT_RUN;
                end
            end
            WDT_RUN:
            begin
                if (!enabled)
                begin
                    nxt_state = WDT_OFF;
                    nxt_cnt   = '0;
                end
                else if (lowpwr)
                begin
                    nxt_state = WDT_HOLD;
                    if (clks_ff)
                    begin
                        nxt_cnt = '0;
                    end
                end
                else if (opt_init)
                begin
                    nxt_cnt = '0;
                end
                else if (svc_done)
                begin
                    nxt_cnt = '0;
                end
                else if (step)
                begin
                    if (cnt_ff >= limit - 1'b1)
                    begin
                        nxt_rst_req = 1'b1;
                        nxt_cause   = 1'b1;
                        nxt_cnt     = '0;
                    end
                    else
                    begin
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                end
            end
            WDT_HOLD:
            begin
                if (clks_ff)
                begin
                    nxt_cnt = '0;
                end
                else if (opt_init || svc_done)
                begin
                    nxt_cnt = '0;
                end
                if (!enabled)
                begin
                    nxt_state = WDT_OFF;
                    nxt_cnt   = '0;
                end
                else if (!lowpwr)
                begin
                    nxt_state = WDT_RUN;
                end
            end
            default:
            begin
                nxt_state = WDT_OFF;
            end
        endcase
        if (bad_req || early_req)
        begin
            nxt_rst_req = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_ff   <= WDT_RUN;
            cnt_ff     <= '0;
            rst_req_ff <= 1'b0;
            cause_ff   <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            rst_req_ff <= nxt_rst_req;
            cause_ff   <= nxt_cause;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    logic running_ff;
    logic nxt_running;

    always_comb
    begin
        nxt_running = (nxt_state == WDT_RUN);
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            running_ff <= 1'b1;
        end
        else
        begin
            running_ff <= nxt_running;
        end
    end

    assign system_reset_req = rst_req_ff;
    assign cause_watchdog   = cause_ff;
    assign timeout_select   = tsel_ff;
    assign clock_select     = clks_ff;
    assign window_enable    = win_ff;
    assign watchdog_running = running_ff;

endmodule : wdt_top

// ### tb/tb_wdt_top.sv
// Purpose: self-checking bench for the windowed watchdog
// Assumes: short divider and short bus timeouts
// Notes:   each scenario resets the block first
`timescale 1ns/1ps
module tb_wdt_top;
    import wdt_pkg::*;
    localparam int DIV = 4;
    logic          clk_sys, reset, por_cause, stop_mode, debug_mode;
    logic          status_wr, opt_one_wr, opt_two_wr;
    logic [7:0]    status_wdata, opt_one_wdata, opt_two_wdata;
    logic          system_reset_req, cause_watchdog, clock_select;
    logic          window_enable, watchdog_running;
    wdt_tsel_type  timeout_select;
    int            fails, checks_done;
    wdt_top #(.BUS_LOG2_1(4), .BUS_LOG2_2(5), .BUS_LOG2_3(6),
        .SLOW_LOG2_1(3), .SLOW_LOG2_2(4), .SLOW_DIV(DIV)) u_wdt_top (
        .clk_sys(clk_sys), .reset(reset), .por_cause(por_cause),
        .status_wr(status_wr), .status_wdata(status_wdata),
        .opt_one_wr(opt_one_wr), .opt_one_wdata(opt_one_wdata),
        .opt_two_wr(opt_two_wr), .opt_two_wdata(opt_two_wdata),
        .stop_mode(stop_mode), .debug_mode(debug_mode),
        .system_reset_req(system_reset_req),
        .cause_watchdog(cause_watchdog), .timeout_select(timeout_select),
        .clock_select(clock_select), .window_enable(window_enable),
        .watchdog_running(watchdog_running));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t seen %0h want %0h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic do_reset();
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
    endtask : do_reset
    task automatic wr(input int sel, input logic [7:0] d);
        status_wdata = d;
        opt_one_wdata = d;
        opt_two_wdata = d;
        case (sel)
            0: status_wr = 1'b1;
            1: opt_one_wr = 1'b1;
            default: opt_two_wr = 1'b1;
        endcase
        tick(1);
        case (sel)
            0: status_wr = 1'b0;
            1: opt_one_wr = 1'b0;
            default: opt_two_wr = 1'b0;
        endcase
    endtask : wr
    task automatic cfg(input logic [7:0] one, input logic [7:0] two);
        wr(1, one);
        wr(2, two);
    endtask : cfg
    task automatic svc(input logic [7:0] b);
        status_wdata = 8'h55;
        status_wr = 1'b1;
        tick(1);
        status_wdata = b;
        tick(1);
        status_wr = 1'b0;
    endtask : svc
    task automatic expect_to(input int lo, input int hi);
        int n;
        n = 0;
        while (system_reset_req !== 1'b1 && n < hi + 8)
        begin
            tick(1);
            n++;
        end
        check(n >= lo && n <= hi, 1'b1);
    endtask : expect_to
    task automatic expect_none(input int k);
        int h;
        h = 0;
        repeat (k)
        begin
            tick(1);
            if (system_reset_req === 1'b1)
                h++;
        end
        check(h, 0);
    endtask : expect_none
    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        do_reset();
        check(timeout_select, 2'h3);
        check({clock_select, window_enable, watchdog_running}, 3'h5);
        expect_to(1024 * DIV - 8, 1024 * DIV + 8);
        tick(1);
        check(cause_watchdog, 1'b1);
        por_cause = 1'b1;
        tick(2);
        check(cause_watchdog, 1'b0);
        por_cause = 1'b0;
    endtask : t_defaults
    task automatic t_lengths();
        logic [7:0] ov [5] = '{8'h40, 8'h80, 8'hC0, 8'h40, 8'h80};
        logic [7:0] tv [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
        int         lv [5] = '{16, 32, 64, 8 * DIV, 16 * DIV};
        for (int i = 0; i < 5; i++)
        begin
            do_reset();
            cfg(ov[i], tv[i]);
            tick(8);
            cfg(ov[i] ^ 8'hC0, tv[i] ^ 8'h03);
            check({timeout_select, clock_select, window_enable},
                {ov[i][7:6], tv[i][0], tv[i][1]});
            expect_to(lv[i] - 13, lv[i] - 4);
        end
    endtask : t_lengths
    task automatic t_disable();
        do_reset();
        cfg(8'h00, 8'h00);
        tick(1);
        check(watchdog_running, 1'b0);
        expect_none(300);
    endtask : t_disable
    task automatic t_service();
        do_reset();
        cfg(8'hC0, 8'h00);
        tick(30);
        wr(0, 8'hAA);
        expect_to(64 - 37, 64 - 28);
        do_reset();
        cfg(8'hC0, 8'h00);
        tick(40);
        svc(8'hAA);
        check({timeout_select, clock_select, window_enable, cause_watchdog},
            5'h18);
        expect_to(64 - 4, 64 + 4);
    endtask : t_service
    task automatic t_bad();
        logic [7:0] bv [4] = '{8'h00, 8'hFF, 8'h54, 8'hAB};
        for (int i = 0; i < 4; i++)
        begin
            do_reset();
            wr(0, bv[i]);
            tick(1);
            check(system_reset_req, 1'b1);
        end
        do_reset();
        svc(8'h33);
        tick(1);
        check(system_reset_req, 1'b1);
    endtask : t_bad
    task automatic t_window();
        do_reset();
        cfg(8'hC0, 8'h02);
        check(window_enable, 1'b1);
        tick(10);
        svc(8'hAA);
        expect_to(0, 3);
        do_reset();
        cfg(8'hC0, 8'h02);
        tick(52);
        svc(8'hAA);
        expect_to(60, 68);
        do_reset();
        cfg(8'h40, 8'h03);
        tick(2);
        svc(8'hAA);
        expect_to(8 * DIV - 4, 8 * DIV + 6);
    endtask : t_window
    task automatic t_stop();
        do_reset();
        cfg(8'hC0, 8'h00);
        tick(30);
        stop_mode = 1'b1;
        expect_none(100);
        stop_mode = 1'b0;
        expect_to(64 - 36, 64 - 26);
        do_reset();
        cfg(8'h40, 8'h01);
        tick(20);
        debug_mode = 1'b1;
        expect_none(50);
        debug_mode = 1'b0;
        expect_to(8 * DIV - 4, 8 * DIV + 6);
    endtask : t_stop
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial
    begin
        #400000;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        {fails, checks_done} = '0;
        {reset, por_cause, stop_mode, debug_mode} = 4'h8;
        {status_wr, opt_one_wr, opt_two_wr} = 3'h0;
        {status_wdata, opt_one_wdata, opt_two_wdata} = '0;
        t_defaults();
        t_lengths();
        t_disable();
        t_service();
        t_bad();
        t_window();
        t_stop();
        tally_and_finish();
    end
endmodule : tb_wdt_top

bind wdt_top wdt_top_props u_wdt_top_props (
    .clk_sys(clk_sys), .reset(reset), .status_wr(status_wr),
    .status_wdata(status_wdata), .opt_one_wr(opt_one_wr),
    .opt_one_wdata(opt_one_wdata), .opt_two_wr(opt_two_wr),
    .opt_two_wdata(opt_two_wdata), .stop_mode(stop_mode),
    .debug_mode(debug_mode), .system_reset_req(system_reset_req),
    .timeout_select(timeout_select), .clock_select(clock_select),
    .window_enable(window_enable), .watchdog_running(watchdog_running));

// ### tb/wdt_top_props.sv
// Purpose: assertions on the watchdog top ports
// Assumes: writes are one-cycle strobes
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module wdt_top_props (
    // clock and reset
    input wire logic                  clk_sys,
    input wire logic                  reset,
    // writes and modes
    input wire logic                  status_wr,
    input wire logic [7:0]            status_wdata,
    input wire logic                  opt_one_wr,
    input wire logic [7:0]            opt_one_wdata,
    input wire logic                  opt_two_wr,
    input wire logic [7:0]            opt_two_wdata,
    input wire logic                  stop_mode,
    input wire logic                  debug_mode,
    // outputs
    input wire logic                  system_reset_req,
    input wire wdt_pkg::wdt_tsel_type timeout_select,
    input wire logic                  clock_select,
    input wire logic                  window_enable,
    input wire logic                  watchdog_running
);
    import wdt_pkg::*;
    logic       one_ff;
    logic       nxt_one;
    logic       two_ff;
    logic       nxt_two;
    logic [1:0] one_tsel;
    logic [1:0] two_bits;
    assign one_tsel = opt_one_wdata[7:6];
    assign two_bits = opt_two_wdata[1:0];
    always_comb
    begin
        nxt_one = one_ff | opt_one_wr;
        nxt_two = two_ff | opt_two_wr;
    end
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            one_ff <= 1'b0;
            two_ff <= 1'b0;
        end
        else
        begin
            one_ff <= nxt_one;
            two_ff <= nxt_two;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    rst_defaults_a: assert property (
        $fell(reset) |-> timeout_select == 2'h3 && clock_select
        && !window_enable && watchdog_running)
        else $error("bad state after reset");
    bad_write_a: assert property (
        status_wr && status_wdata != 8'h55 && status_wdata != 8'hAA
        |-> ##2 system_reset_req)
        else $error("bad status write did not reset");
    req_pulse_a: assert property (
        system_reset_req |=> !system_reset_req)
        else $error("reset request longer than a cycle");
    lock_one_a: assert property (
        one_ff |=> $stable(timeout_select))
        else $error("options one changed after lock");
    lock_two_a: assert property (
        two_ff |=> $stable(clock_select) && $stable(window_enable))
        else $error("options two changed after lock");
    take_one_a: assert property (
        opt_one_wr && !one_ff |=> timeout_select == $past(one_tsel))
        else $error("options one first write not taken");
    take_two_a: assert property (
        opt_two_wr && !two_ff
        |=> {window_enable, clock_select} == $past(two_bits))
        else $error("options two first write not taken");
    off_quiet_a: assert property (
        timeout_select == 2'h0 ##1 timeout_select == 2'h0
        |-> !watchdog_running)
        else $error("watchdog running while disabled");
    stop_hold_a: assert property (
        (stop_mode || debug_mode) [*3] |-> !system_reset_req)
        else $error("timeout during stop or debug");
    cover property (status_wr ##2 system_reset_req);
    cover property (stop_mode && !clock_select);
    cover property (opt_two_wr && opt_two_wdata[1] && !two_ff);
endmodule : wdt_top_props
